// File: hw/plb_regs.svh
// Overview of operation
// - slew-rate word 27h, default 0.125 mV/us, exponents 0 to -4 only.
// - scale word 29h takes 1, 0.5, 0.25, 0.125 at exponent -3; default 1.
// - frequency word 33h in kHz, 166 to 1500, exponent 0 or 1, default 978.
// - conversion starts once input reaches turn-on level 35h, default 8 V.
// - running conversion stops when input falls to turn-off level 36h, default 7 V.
// - current-sense offset 39h is added to measured current, default 0 A.
// - output overvoltage fault level 40h compared with sensed output, default 1.398 V.
// - response bytes 41h, 45h, 56h pick ignore or shutdown; 41h defaults shutdown.
// - output-high warning when sensed output exceeds 42h, default 1.301 V.
// - output-low warning when sensed output falls below 43h, default 0.75 V.
// - output undervoltage fault when sensed output falls below 44h, default 0.680 V.
// - overcurrent fault level 46h, 0.5 A steps, default 40 A, raises fault.
// - overcurrent response 47h defaults to 8-cycle limiting, then hiccup, retry 20 ms.
// - overcurrent warning level 4Ah, default 35 A, raises warning when exceeded.
// - overtemperature fault level 4Fh, 1 degree steps, exponent 0, default 125 C.
// - overtemperature response 50h: ignore, shutdown or inhibit; default auto restart.
// - overtemperature warning level 51h, 1 degree steps, default 105 C.
// - input overvoltage fault level 55h, exponent -2, default 15 V.
// - output overvoltage fault sets bit 5 of summary status byte 78h.
`ifndef PLB_REGS_SVH
`define PLB_REGS_SVH

// command codes
`define CMD_SLEW        8'h27
`define CMD_SCALE       8'h29
`define CMD_FREQ        8'h33
`define CMD_INPUT_TURN_ON_LEVEL      8'h35
`define CMD_INPUT_TURN_OFF_LEVEL     8'h36
`define CMD_CAL_OFS     8'h39
`define CMD_OVF_LVL     8'h40
`define CMD_OVF_ACT     8'h41
`define CMD_OVW_LVL     8'h42
`define CMD_UVW_LVL     8'h43
`define CMD_UVF_LVL     8'h44
`define CMD_UVF_ACT     8'h45
`define CMD_OCF_LVL     8'h46
`define CMD_OCF_ACT     8'h47
`define CMD_OCW_LVL     8'h4a
`define CMD_OTF_LVL     8'h4f
`define CMD_OTF_ACT     8'h50
`define CMD_OTW_LVL     8'h51
`define CMD_VINOV_LVL   8'h55
`define CMD_VINOV_ACT   8'h56
`define CMD_STATUS      8'h78

// reset values (linear words: exponent in 15:11, mantissa in 10:0)
`define DEF_SLEW        16'he801
`define DEF_SCALE       16'he808
`define DEF_FREQ        16'h03d2
`define DEF_INPUT_TURN_ON_LEVEL      16'hf810
`define DEF_INPUT_TURN_OFF_LEVEL     16'hf80e
`define DEF_CAL_OFS     16'hf800
`define DEF_OVF_LVL     16'h0166
`define DEF_OVF_ACT     16'h0080
`define DEF_OVW_LVL     16'h014d
`define DEF_UVW_LVL     16'h00c0
`define DEF_UVF_LVL     16'h00ae
`define DEF_UVF_ACT     16'h0000
`define DEF_OCF_LVL     16'hf850
`define DEF_OCF_ACT     16'h007c
`define DEF_OCW_LVL     16'hf846
`define DEF_OTF_LVL     16'h007d
`define DEF_OTF_ACT     16'h00c0
`define DEF_OTW_LVL     16'h0069
`define DEF_VINOV_LVL   16'hf03c
`define DEF_VINOV_ACT   16'h0000

// field positions and exponent limits
`define EXP_MSB         15
`define EXP_LSB         11
`define MANT_MSB        10
`define ACT_MSB         7
`define ACT_LSB         6
`define EXP_SLEW_MIN    (-5'sd4)
`define EXP_ZERO        (5'sd0)
`define EXP_ONE         (5'sd1)
`define EXP_HALF        (-5'sd1)
`define EXP_QUARTER     (-5'sd2)
`define EXP_EIGHTH      (-5'sd3)
`define FREQ_MIN_KHZ    13'sd166
`define FREQ_MAX_KHZ    13'sd1500
`define STS_OFF_BIT     6
`define STS_OV_BIT      5
`define STS_OC_BIT      4
`define STS_OT_BIT      2
`define STS_NONE_BIT    0

// timing
`define OC_LIMIT_CYCLES 4'd8
`define HICCUP_MS       20
`define SYS_CLK_KHZ     125000

`endif

// File: hw/plb_pkg.sv
package plb_pkg;
  typedef enum logic [1:0] {PLB_ACT_IGNORE, PLB_ACT_LIMIT, PLB_ACT_SHUT, PLB_ACT_RESTART} plb_act_t;
  typedef enum {PLB_LK_IDLE, PLB_LK_ADDR, PLB_LK_CMD, PLB_LK_WDAT, PLB_LK_RDAT} plb_link_st_t;
  typedef enum {PLB_OC_NORMAL, PLB_OC_LIMIT, PLB_OC_HICCUP} plb_oc_st_t;
  typedef struct packed {
    logic        [11:0] vout;  // 1/256 V
    logic        [11:0] vin;   // 0.25 V
    logic signed [11:0] iout;  // 0.25 A
    logic        [7:0]  temp;  // 1 C
  } plb_sense_t;
  typedef struct packed {
    logic [15:0] slew;
    logic [15:0] scale;
    logic [15:0] freq;
    logic [15:0] cal_ofs;
  } plb_cfg_t;
  typedef struct packed {
    logic ov_warn;
    logic uv_warn;
    logic oc_warn;
    logic ot_warn;
    logic ov_fault;
    logic uv_fault;
    logic oc_fault;
    logic ot_fault;
    logic vin_ov_fault;
  } plb_flags_t;
endpackage : plb_pkg

// File: hw/plb_bank.sv
`timescale 1ns/100ps
`include "plb_regs.svh"
module plb_bank
  import plb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR      = 7'h40,
  parameter int         HICCUP_CYCLES = `HICCUP_MS * `SYS_CLK_KHZ
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       pmb_scl,
  input  wire logic       pmb_sda_i,
  output logic            pmb_sda_o,
  output logic            pmb_sda_oe,
  input  wire plb_sense_t sense,
  input  wire logic       sw_pulse,
  output plb_cfg_t        cfg,
  output plb_flags_t      flags,
  output logic [7:0]      status_byte,
  output logic            conv_on,
  output logic            oc_limit
);
  localparam int NREG = 20;
  localparam logic [7:0] CMD_TAB [NREG] = '{`CMD_SLEW, `CMD_SCALE, `CMD_FREQ, `CMD_INPUT_TURN_ON_LEVEL, `CMD_INPUT_TURN_OFF_LEVEL,
    `CMD_CAL_OFS, `CMD_OVF_LVL, `CMD_OVF_ACT, `CMD_OVW_LVL, `CMD_UVW_LVL, `CMD_UVF_LVL, `CMD_UVF_ACT,
    `CMD_OCF_LVL, `CMD_OCF_ACT, `CMD_OCW_LVL, `CMD_OTF_LVL, `CMD_OTF_ACT, `CMD_OTW_LVL, `CMD_VINOV_LVL,
    `CMD_VINOV_ACT};
  localparam logic [15:0] DEF_TAB [NREG] = '{`DEF_SLEW, `DEF_SCALE, `DEF_FREQ, `DEF_INPUT_TURN_ON_LEVEL, `DEF_INPUT_TURN_OFF_LEVEL,
    `DEF_CAL_OFS, `DEF_OVF_LVL, `DEF_OVF_ACT, `DEF_OVW_LVL, `DEF_UVW_LVL, `DEF_UVF_LVL, `DEF_UVF_ACT,
    `DEF_OCF_LVL, `DEF_OCF_ACT, `DEF_OCW_LVL, `DEF_OTF_LVL, `DEF_OTF_ACT, `DEF_OTW_LVL, `DEF_VINOV_LVL,
    `DEF_VINOV_ACT};

  // ---------------- link side, clocked by the bus clock ----------------
  plb_link_st_t lk_st;
  logic       start_tgl;
  logic       start_ack;
  logic [3:0] bit_cnt;
  logic [7:0] sh_reg;
  logic       ack_flag;
  logic       byte_idx;
  logic [7:0] cmd_reg;
  logic [7:0] wlo_reg;
  logic [7:0] wr_cmd_reg;
  logic [15:0] wr_data_reg;
  logic       wr_tgl;
  logic       cmd_tgl;
  logic [7:0] rx_byte;
  logic [15:0] rd_word_reg;
  logic [7:0] tx_byte;

  assign rx_byte   = {sh_reg[6:0], pmb_sda_i};
  assign tx_byte   = byte_idx ? rd_word_reg[15:8] : rd_word_reg[7:0];
  assign pmb_sda_o = 1'b0;

  function automatic logic is_byte_cmd(input logic [7:0] c);
    is_byte_cmd = (c == `CMD_OVF_ACT) || (c == `CMD_UVF_ACT) || (c == `CMD_OCF_ACT) ||
                  (c == `CMD_OTF_ACT) || (c == `CMD_VINOV_ACT) || (c == `CMD_STATUS);
  endfunction : is_byte_cmd

  // start condition: data falls while clock is high
  always_ff @(negedge pmb_sda_i or posedge rst) begin
    if (rst) begin
      start_tgl <= 1'b0;
    end else if (pmb_scl) begin
      start_tgl <= ~start_tgl;
    end
  end

  // bit sampling and byte handling on the rising bus clock
  always_ff @(posedge pmb_scl or posedge rst) begin
    if (rst) begin
      lk_st       <= PLB_LK_IDLE;
      start_ack   <= 1'b0;
      bit_cnt     <= 4'h0;
      sh_reg      <= 8'h00;
      ack_flag    <= 1'b0;
      byte_idx    <= 1'b0;
      cmd_reg     <= 8'h00;
      wlo_reg     <= 8'h00;
      wr_cmd_reg  <= 8'h00;
      wr_data_reg <= 16'h0000;
      wr_tgl      <= 1'b0;
      cmd_tgl     <= 1'b0;
    end else if (start_tgl != start_ack) begin
      // a start (or repeated start) resynchronises the byte framing
      start_ack <= start_tgl;
      lk_st     <= PLB_LK_ADDR;
      bit_cnt   <= 4'h1;
      sh_reg    <= {7'h00, pmb_sda_i};
      ack_flag  <= 1'b0;
      byte_idx  <= 1'b0;
    end else if (lk_st != PLB_LK_IDLE) begin
      if (bit_cnt == 4'h8) begin
        // acknowledge slot; a master nack ends a read
        bit_cnt  <= 4'h0;
        ack_flag <= 1'b0;
        if (lk_st == PLB_LK_RDAT) begin
          byte_idx <= ~byte_idx;
          if (pmb_sda_i) begin
            lk_st <= PLB_LK_IDLE;
          end
        end else if (!ack_flag) begin
          lk_st <= PLB_LK_IDLE;
        end
      end else begin
        sh_reg  <= rx_byte;
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt == 4'h7) begin
          unique case (lk_st)
            PLB_LK_ADDR: begin
              ack_flag <= (rx_byte[7:1] == DEV_ADDR);
              // the address ack toggles byte_idx, so a read starts at the low byte
              byte_idx <= rx_byte[0];
              lk_st    <= rx_byte[0] ? PLB_LK_RDAT : PLB_LK_CMD;
            end
            PLB_LK_CMD: begin
              cmd_reg  <= rx_byte;
              cmd_tgl  <= ~cmd_tgl;
              ack_flag <= 1'b1;
              lk_st    <= PLB_LK_WDAT;
            end
            PLB_LK_WDAT: begin
              ack_flag <= 1'b1;
              if (!byte_idx && !is_byte_cmd(cmd_reg)) begin
                wlo_reg  <= rx_byte;
                byte_idx <= 1'b1;
              end else if (!byte_idx) begin
                wr_cmd_reg  <= cmd_reg;
                wr_data_reg <= {8'h00, rx_byte};
                wr_tgl      <= ~wr_tgl;
                byte_idx    <= 1'b1;
              end else if (!is_byte_cmd(cmd_reg) && bit_cnt == 4'h7) begin
                wr_cmd_reg  <= cmd_reg;
                wr_data_reg <= {rx_byte, wlo_reg};
                wr_tgl      <= ~wr_tgl;
              end
            end
            PLB_LK_RDAT: begin
              ack_flag <= 1'b0;
            end
            PLB_LK_IDLE: begin
              ack_flag <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // drive ack and read data while the clock is low; open drain, pull low only
  always_ff @(negedge pmb_scl or posedge rst) begin
    if (rst) begin
      pmb_sda_oe <= 1'b0;
    end else if (start_tgl != start_ack) begin
      pmb_sda_oe <= 1'b0;
    end else if (bit_cnt == 4'h8) begin
      pmb_sda_oe <= ack_flag;
    end else if (lk_st == PLB_LK_RDAT) begin
      pmb_sda_oe <= ~tx_byte[3'h7 - bit_cnt[2:0]];
    end else begin
      pmb_sda_oe <= 1'b0;
    end
  end

  // ---------------- system side ----------------
  logic [15:0] regs_q [NREG];
  logic [2:0]  wr_sync;
  logic [2:0]  cmd_sync;
  logic        wr_evt;
  logic        cmd_evt;
  logic        wr_ok;

  // toggles cross with two flops; the third flop only feeds edge detection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_sync  <= 3'h0;
      cmd_sync <= 3'h0;
    end else begin
      wr_sync  <= {wr_sync[1:0], wr_tgl};
      cmd_sync <= {cmd_sync[1:0], cmd_tgl};
    end
  end
  assign wr_evt  = wr_sync[2] ^ wr_sync[1];
  assign cmd_evt = cmd_sync[2] ^ cmd_sync[1];

  function automatic logic [15:0] fetch(input logic [7:0] c);
    fetch = 16'h0000;
    for (int i = 0; i < NREG; i++) begin
      if (CMD_TAB[i] == c) begin
        fetch = regs_q[i];
      end
    end
  endfunction : fetch

  // exponent and value screening of an incoming write
  function automatic logic legal(input logic [7:0] c, input logic [15:0] d);
    logic signed [4:0]  e;
    logic signed [10:0] m;
    logic signed [12:0] f;
    e = d[`EXP_MSB:`EXP_LSB];
    m = d[`MANT_MSB:0];
    f = 13'(m);
    if (e == `EXP_ONE) begin
      f = f <<< 1;
    end
    unique case (c)
      `CMD_SLEW:  legal = (e <= `EXP_ZERO) && (e >= `EXP_SLEW_MIN);
      `CMD_SCALE: legal = (e == `EXP_EIGHTH) && (m == 11'sd1 || m == 11'sd2 || m == 11'sd4 || m == 11'sd8);
      `CMD_FREQ:  legal = (e == `EXP_ZERO || e == `EXP_ONE) && f >= `FREQ_MIN_KHZ && f <= `FREQ_MAX_KHZ;
      `CMD_INPUT_TURN_ON_LEVEL, `CMD_INPUT_TURN_OFF_LEVEL, `CMD_CAL_OFS, `CMD_OCF_LVL, `CMD_OCW_LVL: legal = (e == `EXP_HALF);
      `CMD_OTF_LVL, `CMD_OTW_LVL: legal = (e == `EXP_ZERO);
      `CMD_VINOV_LVL: legal = (e == `EXP_QUARTER);
      default: legal = 1'b1;
    endcase
  endfunction : legal

  assign wr_ok = legal(wr_cmd_reg, wr_data_reg);

  // one flop bank per command, loaded with its reset value
  for (genvar g = 0; g < NREG; g++) begin : g_reg
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        regs_q[g] <= DEF_TAB[g];
      end else if (wr_evt && wr_ok && wr_cmd_reg == CMD_TAB[g]) begin
        regs_q[g] <= wr_data_reg;
      end
    end
  end

  // readback word, reloaded once per received command byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_word_reg <= 16'h0000;
    end else if (cmd_evt) begin
      rd_word_reg <= (cmd_reg == `CMD_STATUS) ? {8'h00, status_byte} : fetch(cmd_reg);
    end
  end

  // configuration handed to the analogue loop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg <= '{`DEF_SLEW, `DEF_SCALE, `DEF_FREQ, `DEF_CAL_OFS};
    end else begin
      cfg <= '{fetch(`CMD_SLEW), fetch(`CMD_SCALE), fetch(`CMD_FREQ), fetch(`CMD_CAL_OFS)};
    end
  end

  // level scaling into sense units
  logic [12:0]        input_turn_on_level_lvl;
  logic [12:0]        input_turn_off_level_lvl;
  logic signed [13:0] iout_corr;
  logic signed [13:0] ocf_lvl;
  logic signed [13:0] ocw_lvl;
  // table slots: 3 turn-on, 4 turn-off, 5 offset, 12 oc fault, 14 oc warn, 18 input ov
  assign input_turn_on_level_lvl  = {2'b00, regs_q[3][`MANT_MSB:0]} << 1;
  assign input_turn_off_level_lvl = {2'b00, regs_q[4][`MANT_MSB:0]} << 1;
  assign iout_corr   = 14'(sense.iout) + (14'(signed'(regs_q[5][`MANT_MSB:0])) <<< 1);
  assign ocf_lvl     = 14'(signed'(regs_q[12][`MANT_MSB:0])) <<< 1;
  assign ocw_lvl     = 14'(signed'(regs_q[14][`MANT_MSB:0])) <<< 1;

  // threshold comparators; warnings and faults alike are registered flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags <= '0;
    end else begin
      flags.ov_fault     <= {4'h0, sense.vout} > fetch(`CMD_OVF_LVL);
      flags.ov_warn      <= {4'h0, sense.vout} > fetch(`CMD_OVW_LVL);
      flags.uv_warn      <= {4'h0, sense.vout} < fetch(`CMD_UVW_LVL);
      flags.uv_fault     <= {4'h0, sense.vout} < fetch(`CMD_UVF_LVL);
      flags.oc_fault     <= iout_corr > ocf_lvl;
      flags.oc_warn      <= iout_corr > ocw_lvl;
      flags.ot_fault     <= {8'h00, sense.temp} > fetch(`CMD_OTF_LVL);
      flags.ot_warn      <= {8'h00, sense.temp} > fetch(`CMD_OTW_LVL);
      // input overvoltage compare
      // mantissa only: the exponent field would swamp a raw compare
      flags.vin_ov_fault <= {1'b0, sense.vin} > {2'b00, regs_q[18][`MANT_MSB:0]};
    end
  end

  plb_act_t ov_act;
  plb_act_t uv_act;
  plb_act_t oc_act;
  plb_act_t ot_act;
  plb_act_t vin_act;
  assign ov_act  = plb_act_t'(regs_q[7][`ACT_MSB:`ACT_LSB]);
  assign uv_act  = plb_act_t'(regs_q[11][`ACT_MSB:`ACT_LSB]);
  assign oc_act  = plb_act_t'(regs_q[13][`ACT_MSB:`ACT_LSB]);
  assign ot_act  = plb_act_t'(regs_q[16][`ACT_MSB:`ACT_LSB]);
  assign vin_act = plb_act_t'(regs_q[19][`ACT_MSB:`ACT_LSB]);

  // overcurrent: limit for a number of switching cycles, then hiccup off
  plb_oc_st_t oc_st;
  logic [3:0]  oc_cnt;
  logic [31:0] hic_cnt;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oc_st   <= PLB_OC_NORMAL;
      oc_cnt  <= 4'h0;
      hic_cnt <= 32'h0;
    end else begin
      unique case (oc_st)
        PLB_OC_NORMAL: begin
          oc_cnt <= 4'h0;
          if (flags.oc_fault && (oc_act == PLB_ACT_LIMIT || oc_act == PLB_ACT_RESTART)) begin
            oc_st <= PLB_OC_LIMIT;
          end
        end
        PLB_OC_LIMIT: begin
          if (!flags.oc_fault) begin
            oc_st <= PLB_OC_NORMAL;
          end else if (oc_cnt == `OC_LIMIT_CYCLES) begin
            oc_st   <= PLB_OC_HICCUP;
            hic_cnt <= 32'(HICCUP_CYCLES);
          end else if (sw_pulse) begin
            oc_cnt <= oc_cnt + 4'h1;
          end
        end
        PLB_OC_HICCUP: begin
          hic_cnt <= hic_cnt - 32'h1;
          if (hic_cnt <= 32'h1) begin
            oc_st <= PLB_OC_NORMAL;
          end
        end
      endcase
    end
  end
  assign oc_limit = (oc_st == PLB_OC_LIMIT);

  // latched shutdown, released only when the input drops to turn-off level
  logic shut_q;
  logic shut_set;
  logic ot_inh;
  logic blocked;
  logic vin_low;
  assign shut_set = (flags.ov_fault && ov_act == PLB_ACT_SHUT) || (flags.uv_fault && uv_act == PLB_ACT_SHUT) ||
                    (flags.vin_ov_fault && vin_act == PLB_ACT_SHUT) || (flags.oc_fault && oc_act == PLB_ACT_SHUT) ||
                    (flags.ot_fault && ot_act == PLB_ACT_SHUT);
  assign ot_inh   = flags.ot_fault && (ot_act == PLB_ACT_LIMIT || ot_act == PLB_ACT_RESTART);
  assign blocked  = shut_q || ot_inh || (oc_st == PLB_OC_HICCUP);
  assign vin_low  = {1'b0, sense.vin} <= input_turn_off_level_lvl;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shut_q <= 1'b0;
    end else if (shut_set) begin
      shut_q <= 1'b1;
    end else if (vin_low) begin
      shut_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conv_on <= 1'b0;
    end else if (blocked || vin_low) begin
      conv_on <= 1'b0;
    end else if ({1'b0, sense.vin} >= input_turn_on_level_lvl) begin
      conv_on <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_byte <= 8'h00;
    end else begin
      status_byte                 <= 8'h00;
      status_byte[`STS_OFF_BIT]   <= ~conv_on;
      status_byte[`STS_OV_BIT]    <= flags.ov_fault;
      status_byte[`STS_OC_BIT]    <= flags.oc_fault;
      status_byte[`STS_OT_BIT]    <= flags.ot_fault;
      status_byte[`STS_NONE_BIT]  <= ~(flags.ov_fault | flags.oc_fault | flags.ot_fault | ~conv_on);
    end
  end

  // ---------------- checks ----------------
  // status follows fault
  a_ov_status_bit: assert property (@(posedge sys_clk) disable iff (rst)
    flags.ov_fault |=> status_byte[`STS_OV_BIT]) else $error("ov fault not in status bit 5");
  a_scale_set: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.scale == 16'he801 || cfg.scale == 16'he802 || cfg.scale == 16'he804 || cfg.scale == 16'he808)
    else $error("scale word outside allowed set");
  a_freq_range: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.freq[15:11] == 5'h00 || cfg.freq[15:11] == 5'h01) else $error("frequency exponent illegal");
  a_bad_exp_kept: assert property (@(posedge sys_clk) disable iff (rst)
    wr_evt && !wr_ok && wr_cmd_reg == `CMD_SLEW |=> $stable(regs_q[0])) else $error("illegal write stored");
  a_start_level: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(conv_on) |-> $past({1'b0, sense.vin}) >= $past(input_turn_on_level_lvl)) else $error("start below turn-on");
  a_stop_level: assert property (@(posedge sys_clk) disable iff (rst)
    vin_low |=> !conv_on) else $error("still converting below turn-off");
  a_warn_no_stop: assert property (@(posedge sys_clk) disable iff (rst)
    conv_on && !blocked && !vin_low |=> conv_on) else $error("conversion stopped without fault");
  a_hiccup_off: assert property (@(posedge sys_clk) disable iff (rst)
    oc_st == PLB_OC_HICCUP |=> !conv_on) else $error("converting during hiccup");
  a_shut_latch: assert property (@(posedge sys_clk) disable iff (rst)
    shut_set |=> shut_q ##1 !conv_on) else $error("shutdown response not taken");
  a_oc_warn: assert property (@(posedge sys_clk) disable iff (rst)
    iout_corr > ocw_lvl && $stable(iout_corr) |=> flags.oc_warn) else $error("oc warning missed");
endmodule : plb_bank

// File: verification/plb_host_model.sv
`timescale 1ns/100ps
module plb_host_model #(
  parameter logic [6:0] ADDR = 7'h40
) (
  output logic      scl,
  output logic      sda_oe,
  input  wire logic sda
);
  logic [7:0] q;
  logic       nk;
  // clock idles high between frames
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_oe = ~b;
    #16 scl = 1'b1;
    #16 r = sda;
    #16 scl = 1'b0;
    #16;
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(last, nak);
  endtask : xfer
  task automatic start;
    sda_oe = 1'b0;
    #16 scl = 1'b1;
    #16 sda_oe = 1'b1;
    #16 scl = 1'b0;
    #16;
  endtask : start
  task automatic stop;
    sda_oe = 1'b1;
    #16 scl = 1'b1;
    #16 sda_oe = 1'b0;
    #32;
  endtask : stop
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input logic word, output logic nak);
    logic [3:0] n;
    n = 4'h0;
    start;
    xfer({ADDR, 1'b0}, 1'b1, q, n[0]);
    xfer(cmd, 1'b1, q, n[1]);
    xfer(d[7:0], 1'b1, q, n[2]);
    if (word) xfer(d[15:8], 1'b1, q, n[3]);
    stop;
    nak = |n;
  endtask : wr
  // byte reads end after one byte
  task automatic rd(input logic [7:0] cmd, input logic word, output logic [15:0] d);
    start;
    xfer({ADDR, 1'b0}, 1'b1, q, nk);
    xfer(cmd, 1'b1, q, nk);
    start;
    xfer({ADDR, 1'b1}, 1'b1, q, nk);
    xfer(8'hff, ~word, d[7:0], nk);
    d[15:8] = 8'h00;
    if (word) xfer(8'hff, 1'b1, d[15:8], nk);
    stop;
  endtask : rd
endmodule : plb_host_model

// File: verification/plb_bank_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin miscompares++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module plb_bank_tb;
  import plb_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        sw_pulse = 1'b0;
  plb_sense_t  sense = '0;
  plb_cfg_t    cfg;
  plb_flags_t  flags;
  logic [7:0]  status_byte;
  logic        conv_on, oc_limit, scl, host_oe, dut_oe, nak;
  logic [15:0] rv;
  int          miscompares = 0;
  int          comparisons = 0;
  // open drain with pull-up
  wire         sda = ~(host_oe | dut_oe);
  // {word, command, reset value}
  localparam logic [27:0] DEFS [20] = '{28'h127e801, 28'h129e808, 28'h13303d2, 28'h135f810, 28'h136f80e,
    28'h139f800, 28'h1400166, 28'h0410080, 28'h142014d, 28'h14300c0, 28'h14400ae, 28'h0450000, 28'h146f850,
    28'h047007c, 28'h14af846, 28'h14f007d, 28'h05000c0, 28'h1510069, 28'h155f03c, 28'h0560000};
  always #4 sys_clk = ~sys_clk;
  plb_bank #(.HICCUP_CYCLES(50)) i_dut (.sys_clk(sys_clk), .rst(rst), .pmb_scl(scl), .pmb_sda_i(sda),
    .pmb_sda_o(), .pmb_sda_oe(dut_oe), .sense(sense), .sw_pulse(sw_pulse), .cfg(cfg), .flags(flags),
    .status_byte(status_byte), .conv_on(conv_on), .oc_limit(oc_limit));
  plb_host_model i_host (.scl(scl), .sda_oe(host_oe), .sda(sda));
  task automatic st(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : st
  task automatic t_defaults;
    foreach (DEFS[i]) begin
      i_host.rd(DEFS[i][23:16], DEFS[i][24], rv);
      `CHK("reset", DEFS[i][15:0], rv)
    end
  endtask : t_defaults
  task automatic t_write;
    i_host.wr(8'h27, 16'he005, 1'b1, nak);
    i_host.wr(8'h27, 16'hd805, 1'b1, nak);
    `CHK("ack", 1'b0, nak)
    i_host.wr(8'h29, 16'he804, 1'b1, nak);
    i_host.wr(8'h29, 16'he803, 1'b1, nak);
    i_host.wr(8'h33, 16'h0aee, 1'b1, nak);
    i_host.wr(8'h33, 16'h1100, 1'b1, nak);
    st(8);
    `CHK("cfg", {16'he005, 16'he804, 16'h0aee, 16'hf800}, cfg)
    i_host.wr(8'h29, 16'he808, 1'b1, nak);
    i_host.start;
    i_host.xfer(8'h82, 1'b1, rv[7:0], nak);
    i_host.stop;
    `CHK("no ack", 1'b1, nak)
  endtask : t_write
  task automatic t_conv;
    sense.vout = 12'h100;
    sense.vin = 12'd31; st(4); `CHK("conv", 1'b0, conv_on)
    sense.vin = 12'd32; st(4); `CHK("conv", 1'b1, conv_on)
    sense.vin = 12'd29; st(4); `CHK("conv", 1'b1, conv_on)
    sense.vin = 12'd28; st(4); `CHK("conv", 1'b0, conv_on)
    sense.vin = 12'd61; st(4); `CHK("vin ov", 10'h003, {flags, conv_on})
    sense.vin = 12'd32; st(4);
  endtask : t_conv
  task automatic t_vout;
    sense.vout = 12'h14e; st(4); `CHK("ov warn", 10'h201, {flags, conv_on})
    sense.vout = 12'h0ad; st(4); `CHK("uv", 10'h111, {flags, conv_on})
    sense.vout = 12'h167; st(4); `CHK("ov", 10'h220, {flags, conv_on})
    i_host.rd(8'h78, 1'b0, rv);
    `CHK("status", 16'h0060, rv)
    st(1);
    sense.vout = 12'h100; sense.vin = 12'd28; st(4);
    sense.vin = 12'd32; st(4); `CHK("restart", 1'b1, conv_on)
  endtask : t_vout
  task automatic t_oc;
    sense.iout = 12'sd141; st(4); `CHK("oc warn", 10'h081, {flags, conv_on})
    sense.iout = 12'sd161; st(4); `CHK("oc", 2'b11, {flags.oc_fault, oc_limit})
    repeat (8) begin sw_pulse = 1'b1; st(1); sw_pulse = 1'b0; st(1); end
    st(2); `CHK("hiccup", 2'b00, {oc_limit, conv_on})
    sense.iout = 12'sd0; st(60); `CHK("retry", 1'b1, conv_on)
    i_host.wr(8'h39, 16'hf814, 1'b1, nak);
    st(1);
    sense.iout = 12'sd100; st(8); `CHK("cal", 1'b0, flags.oc_warn)
    sense.iout = 12'sd101; st(4); `CHK("cal", 1'b1, flags.oc_warn)
  endtask : t_oc
  task automatic t_ot;
    sense.iout = 12'sd0; sense.temp = 8'd106; st(4); `CHK("ot warn", 10'h041, {flags, conv_on})
    sense.temp = 8'd126; st(4); `CHK("ot", 10'h044, {flags, conv_on})
    sense.temp = 8'd25; st(4); `CHK("ot off", 10'h001, {flags, conv_on})
  endtask : t_ot
  task automatic finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    st(6);
    rst = 1'b0;
    st(2);
    t_defaults;
    t_write;
    t_conv;
    t_vout;
    t_oc;
    t_ot;
    finish_test;
  end
  // hang guard
  initial begin
    #400us miscompares++;
    finish_test;
  end
endmodule : plb_bank_tb
